// ==== hdl/pwm_setup_pkg.sv ====
// package: register map, field layout and time-base constants for the low-level pwm block
package pwm_setup_pkg;
    localparam logic [7:0]  SETUP_INDEX     = 8'h53;
    localparam logic [31:0] SETUP_BYTE_ADDR = {22'h0, SETUP_INDEX, 2'h0};
    localparam logic [15:0] SETUP_RESET     = 16'h007F;
    localparam int          TB_MSB          = 15;
    localparam int          TB_LSB          = 14;
    localparam int          HC_MSB          = 13;
    localparam int          HC_LSB          = 7;
    localparam int          LC_MSB          = 6;
    localparam int          LC_LSB          = 0;
    localparam int          TB_UNIT_FAST    = 16;
    localparam int          TB_UNIT_MID     = 64;
    localparam int          TB_UNIT_SLOW    = 1024;
    localparam logic [1:0]  TB_SEL_FAST     = 2'h0;
    localparam logic [1:0]  TB_SEL_MID      = 2'h1;
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
    typedef enum logic [0:0] {
        HIGH_PHASE = 1'b0,
        LOW_PHASE  = 1'b1
    } phase_e;
endpackage : pwm_setup_pkg

// ==== hdl/time_unit_if.sv ====
// interface: time-base selection out to the divider and unit tick back
`timescale 1ns/10ps
`default_nettype none
interface time_unit_if;
    logic [1:0] pwm_time_base_select;
    logic       unit_tick;
    modport owner (output pwm_time_base_select, input unit_tick);
    modport divider (input pwm_time_base_select, output unit_tick);
endinterface : time_unit_if
`default_nettype wire

// ==== hdl/time_unit_divider.sv ====
// module: divides hclk into the selected pwm time unit, one-cycle tick per unit
`timescale 1ns/10ps
`default_nettype none
module time_unit_divider
    import pwm_setup_pkg::*;
(
    input  wire logic     hclk,
    input  wire logic     hresetn,
    time_unit_if.divider  tu
);
    logic [9:0] unit_cnt;
    logic [9:0] unit_last;
    logic [1:0] sel_seen;

    always_comb
    begin
        unique case (tu.pwm_time_base_select)
            TB_SEL_FAST: unit_last = 10'(TB_UNIT_FAST - 1);
            TB_SEL_MID:  unit_last = 10'(TB_UNIT_MID - 1);
            default:     unit_last = 10'(TB_UNIT_SLOW - 1);
        endcase
    end

    // restart the unit whenever the selection changes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            unit_cnt     <= 10'h000;
            sel_seen     <= 2'h0;
            tu.unit_tick <= 1'b0;
        end
        else
        begin
            sel_seen <= tu.pwm_time_base_select;
            if (sel_seen != tu.pwm_time_base_select)
            begin
                unit_cnt     <= 10'h000;
                tu.unit_tick <= 1'b0;
            end
            else if (unit_cnt >= unit_last)
            begin
                unit_cnt     <= 10'h000;
                tu.unit_tick <= 1'b1;
            end
            else
            begin
                unit_cnt     <= unit_cnt + 10'h001;
                tu.unit_tick <= 1'b0;
            end
        end
    end
endmodule : time_unit_divider
`default_nettype wire

// ==== hdl/low_level_pwm.sv ====
// module: low-level pwm setup register on ahb-lite and the waveform generator
// What this block does
// - bits 15:14 select the pwm time unit
// - encoder shares the same time unit tick
// - select 00b gives 16 clock periods
// - select 01b gives 64 clock periods
// - select 10b and 11b give 1024 periods
// - bits 13:7 hold the high phase count
// - period is high plus low, times unit
// - high phase lasts high count times unit
// - zero high count holds output static low
// - both counts zero holds output static low
// - setup register at 53h resets to 007Fh
// - bits 6:0 low count sets low phase
// - zero low, nonzero high holds static high
`timescale 1ns/10ps
`default_nettype none
module low_level_pwm
    import pwm_setup_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             low_level_wave,
    output logic             encoder_time_tick
);
    logic [15:0] pin_low_level_pwm_setup;
    logic        wr_pending;
    logic        addr_hit;
    logic [6:0]  cur_high;
    logic [6:0]  cur_low;
    logic [6:0]  phase_units;
    logic [6:0]  next_phase_units;
    phase_e      phase;
    logic        unit_tick_seen;

    time_unit_if tu ();

    time_unit_divider u_divider (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tu      (tu.divider)
    );

    // register slave: zero wait, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_hit  = (haddr == SETUP_BYTE_ADDR);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pending <= 1'b0;
        end
        else if (hready)
        begin
            wr_pending <= hsel && htrans[1] && hwrite && addr_hit;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (hready && hsel && htrans[1] && !hwrite)
        begin
            hrdata <= addr_hit ? {16'h0000, pin_low_level_pwm_setup} : 32'h0000_0000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_low_level_pwm_setup <= SETUP_RESET;
        end
        else if (wr_pending)
        begin
            pin_low_level_pwm_setup <= hwdata[15:0];
        end
    end

    assign tu.pwm_time_base_select = pin_low_level_pwm_setup[TB_MSB:TB_LSB];
    assign encoder_time_tick       = tu.unit_tick;

    // phase unit counter advanced on each time unit
    always_comb
    begin
        next_phase_units = phase_units + 7'h01;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase          <= HIGH_PHASE;
            phase_units    <= 7'h00;
            cur_high       <= SETUP_RESET[HC_MSB:HC_LSB];
            cur_low        <= SETUP_RESET[LC_MSB:LC_LSB];
            unit_tick_seen <= 1'b0;
        end
        else if (tu.unit_tick)
        begin
            unit_tick_seen <= 1'b1;
            if (!unit_tick_seen || cur_high == 7'h00 || cur_low == 7'h00)
            begin
                // static or first unit: pick up the current counts, start high
                phase       <= HIGH_PHASE;
                phase_units <= 7'h00;
                cur_high    <= pin_low_level_pwm_setup[HC_MSB:HC_LSB];
                cur_low     <= pin_low_level_pwm_setup[LC_MSB:LC_LSB];
            end
            else
            begin
                unique case (phase)
                    HIGH_PHASE:
                    begin
                        if (next_phase_units == cur_high)
                        begin
                            phase       <= LOW_PHASE;
                            phase_units <= 7'h00;
                        end
                        else
                        begin
                            phase_units <= next_phase_units;
                        end
                    end
                    LOW_PHASE:
                    begin
                        if (next_phase_units == cur_low)
                        begin
                            // period of high plus low units ends here
                            phase       <= HIGH_PHASE;
                            phase_units <= 7'h00;
                            cur_high    <= pin_low_level_pwm_setup[HC_MSB:HC_LSB];
                            cur_low     <= pin_low_level_pwm_setup[LC_MSB:LC_LSB];
                        end
                        else
                        begin
                            phase_units <= next_phase_units;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            low_level_wave <= 1'b0;
        end
        else if (cur_high == 7'h00)
        begin
            low_level_wave <= 1'b0;
        end
        else if (cur_low == 7'h00)
        begin
            low_level_wave <= 1'b1;
        end
        else
        begin
            low_level_wave <= (phase == HIGH_PHASE);
        end
    end
endmodule : low_level_pwm
`default_nettype wire

// ==== testbench/pwm_monitor.sv ====
// checker: bus and waveform relations of the low-level pwm block
`timescale 1ns/10ps
`default_nettype none
module pwm_monitor
    import pwm_setup_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        low_level_wave,
    input wire logic        encoder_time_tick
);
    logic [15:0] reg_q;
    logic        wr_p;
    logic        chg;
    int          gap;
    int          unit;
    wire         take = hsel && hready && htrans[1];
    wire         hit  = haddr == SETUP_BYTE_ADDR;
    assign unit = reg_q[15] ? TB_UNIT_SLOW : reg_q[14] ? TB_UNIT_MID : TB_UNIT_FAST;
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn) wr_p <= 1'b0;
        else wr_p <= take && hwrite && hit;
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn) reg_q <= SETUP_RESET;
        else if (wr_p) reg_q <= hwdata[15:0];
    // a select change restarts the divider, so skip that interval
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn) chg <= 1'b1;
        else if (wr_p && hwdata[15:14] != reg_q[15:14]) chg <= 1'b1;
        else if (encoder_time_tick) chg <= 1'b0;
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn) gap <= 0;
        else gap <= encoder_time_tick ? 0 : gap + 1;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_TICK_GAP: assert property (encoder_time_tick && !chg |-> gap == unit - 1)
        else $error("tick spacing differs from unit");
    AST_TICK_PULSE: assert property (encoder_time_tick |=> !encoder_time_tick)
        else $error("tick longer than one cycle");
    AST_READY: assert property (hreadyout)
        else $error("wait state inserted");
    AST_OKAY: assert property (!hresp)
        else $error("error response");
    AST_READBACK: assert property (take && !hwrite && hit && !wr_p |=> hrdata == {16'h0000, $past(reg_q)})
        else $error("readback differs");
    AST_UNMAPPED: assert property (take && !hwrite && !hit |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    AST_RISE: assert property ($rose(low_level_wave) |-> $past(encoder_time_tick) || $past(encoder_time_tick, 2))
        else $error("wave rose off a unit edge");
    AST_FALL: assert property ($fell(low_level_wave) |-> $past(encoder_time_tick) || $past(encoder_time_tick, 2))
        else $error("wave fell off a unit edge");
    cover property (take && !hwrite && hit);
    cover property ($rose(low_level_wave));
    cover property (encoder_time_tick && reg_q[15:14] == 2'h3);
endmodule : pwm_monitor
bind low_level_pwm pwm_monitor u_mon (.*);
`default_nettype wire

// ==== testbench/tb.sv ====
// testbench: ahb-lite driver, register model and pwm timing checks
`timescale 1ns/10ps
`default_nettype none
module tb
    import pwm_setup_pkg::*;
;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] reg_m = 32'h7F;
    logic        hreadyout;
    logic        hresp;
    logic        wave;
    logic        tick;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          seed = 32'h8CC4;
    int          c, h, l, u, n, hi, lo;
    low_level_pwm u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .low_level_wave(wave), .encoder_time_tick(tick));
    initial forever #50 hclk = ~hclk;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("FAIL %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic acc(input bit w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        {hsel, htrans, haddr, hwrite} <= {1'b1, HTRANS_NONSEQ, a, w};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        if (w && a == SETUP_BYTE_ADDR) reg_m = {16'h0, d[15:0]};
        if (!w) chk("hrdata", (a == SETUP_BYTE_ADDR) ? reg_m : 32'h0, hrdata);
    endtask : acc
    task automatic run(input logic v, input int m, output int k);
        k = 0;
        while (wave === v && k < m)
        begin
            @(negedge hclk);
            k++;
        end
    endtask : run
    task automatic complete_run;
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    initial
    begin
        repeat (90000) @(posedge hclk);
        mismatches++;
        complete_run();
    end
    initial
    begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        acc(0, SETUP_BYTE_ADDR, 32'h0);
        @(negedge hclk);
        run(1'b0, 3000, n);
        chk("reset wave low", 3000, n);
        for (c = 0; c < 4; c++)
        begin
            h = 1 + ({$random(seed)} % 3);
            l = 1 + ({$random(seed)} % 3);
            acc(1, SETUP_BYTE_ADDR, {16'h0, c[1:0], h[6:0], l[6:0]});
            acc(0, SETUP_BYTE_ADDR, 32'h0);
            u = (c == 0) ? TB_UNIT_FAST : (c == 1) ? TB_UNIT_MID : TB_UNIT_SLOW;
            @(negedge hclk);
            run(1'b1, 8000, n);
            run(1'b0, 8000, n);
            run(1'b1, 8000, hi);
            run(1'b0, 8000, lo);
            chk("high time", h * u, hi);
            chk("low time", l * u, lo);
            chk("period", (h + l) * u, hi + lo);
            @(negedge hclk);
            while (tick !== 1'b1) @(negedge hclk);
            n = 0;
            do begin @(negedge hclk); n++; end while (tick !== 1'b1 && n < 2000);
            chk("encoder tick gap", u, n);
        end
        for (c = 0; c < 3; c++)
        begin
            h = (c == 2) ? 3 : 0;
            l = (c == 0) ? 5 : 0;
            acc(1, SETUP_BYTE_ADDR, {18'h0, h[6:0], l[6:0]});
            repeat (300) @(posedge hclk);
            @(negedge hclk);
            run(c == 2, 200, n);
            chk("static level", 200, n);
        end
        acc(1, SETUP_BYTE_ADDR + 32'h4, 32'hFFFF);
        acc(0, SETUP_BYTE_ADDR + 32'h4, 32'h0);
        acc(0, SETUP_BYTE_ADDR, 32'h0);
        complete_run();
    end
endmodule : tb
`default_nettype wire
